// >>> dv/tb_vsfrc_top.sv
/*
 * Bench for the frame run control stage: queue-driven source, stalling
 * sink model and a queue scoreboard. Assumes inputs change at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_vsfrc_top;
    localparam int unsigned BUF_DEPTH = 4;
    logic                   sys_clk_in, reset_in, din_valid_in, din_ready_out;
    logic                   dout_valid_out, dout_ready_in, stall_en, rdy_q;
    logic                   ctrl_read_in, ctrl_write_in;
    logic [1:0]             ctrl_address_in;
    logic [31:0]            ctrl_writedata_in, ctrl_readdata_out, frame_ctrl_out, rd, fc;
    vsfrc_pkg::vsfrc_beat_t din_beat_in, dout_beat_out, exp_b;
    vsfrc_pkg::vsfrc_beat_t src_q[$], exp_q[$];  // Beats to send, beats expected out
    int                     errors, check_count, cycles;
    integer                 seed;

    vsfrc_top #(.BUF_DEPTH(BUF_DEPTH)) i_vsfrc_top (.sys_clk_in(sys_clk_in),
        .reset_in(reset_in), .din_valid_in(din_valid_in), .din_beat_in(din_beat_in),
        .din_ready_out(din_ready_out), .dout_beat_out(dout_beat_out),
        .dout_valid_out(dout_valid_out), .dout_ready_in(dout_ready_in),
        .ctrl_address_in(ctrl_address_in), .ctrl_read_in(ctrl_read_in),
        .ctrl_write_in(ctrl_write_in), .ctrl_writedata_in(ctrl_writedata_in),
        .ctrl_readdata_out(ctrl_readdata_out), .frame_ctrl_out(frame_ctrl_out));
    vsfrc_sink_model i_vsfrc_sink_model (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .stall_en_in(stall_en), .dout_ready_out(dout_ready_in));

    // Free-running 40 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    // Ready seen at this edge allows a beat in the coming cycle
    always @(posedge sys_clk_in) rdy_q <= din_ready_out;

    // source sends only after ready; idle data scrambled
    always @(negedge sys_clk_in) begin
        if (rdy_q === 1'b1 && src_q.size() > 0) begin
            din_beat_in  <= src_q.pop_front();
            din_valid_in <= 1'b1;
        end else begin
            din_beat_in  <= vsfrc_pkg::vsfrc_beat_t'($random(seed));
            din_valid_in <= 1'b0;
        end
    end

    // Every output beat must be the next expected one
    always @(negedge sys_clk_in) begin
        if (reset_in === 1'b0 && dout_valid_out === 1'b1) begin
            if (exp_q.size() == 0) exp_b = 'x;  // Nothing was due
            else exp_b = exp_q.pop_front();
            check_beat(exp_b, dout_beat_out);
        end
    end

    // Hang guard, well above the expected few hundred cycles
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    task automatic check_beat(input vsfrc_pkg::vsfrc_beat_t e, input vsfrc_pkg::vsfrc_beat_t g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected beat at %0t: expected %h got %h", $time, e, g);
        end
    endtask : check_beat

    task automatic check_reg(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : check_reg

    // Write takes one cycle, no wait
    task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
        @(negedge sys_clk_in);
        ctrl_address_in   = a;
        ctrl_writedata_in = d;
        ctrl_write_in     = 1'b1;
        @(negedge sys_clk_in);
        ctrl_write_in     = 1'b0;
    endtask : reg_write

    // read held three cycles, data taken at the end
    task automatic reg_read(input logic [1:0] a, output logic [31:0] d);
        @(negedge sys_clk_in);
        ctrl_address_in = a;
        ctrl_read_in    = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        d            = ctrl_readdata_out;
        ctrl_read_in = 1'b0;
    endtask : reg_read

    // Header beat with type, then n random samples, last one ends it
    task automatic send_pkt(input logic [3:0] kind, input int n);
        vsfrc_pkg::vsfrc_beat_t b;
        for (int i = 0; i <= n; i++) begin
            b.data = (i == 0) ? {4'h0, kind} : 8'($random(seed));
            b.sop  = (i == 0);
            b.eop  = (i == n);
            src_q.push_back(b);
            exp_q.push_back(b);
        end
    endtask : send_pkt

    task automatic wait_drain;
        for (int i = 0; i < 600 && exp_q.size() > 0; i++) @(negedge sys_clk_in);
    endtask : wait_drain

    task automatic stop_test;
        $display("errors %0d, checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        {ctrl_read_in, ctrl_write_in, stall_en} = '0;
        {ctrl_address_in, ctrl_writedata_in} = '0;
        {errors, check_count} = '0;
        seed     = 32'h23C9;
        reset_in = 1'b1;
        repeat (16) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        reset_in = 1'b0;
        reg_write(2'h0, 32'h0000_0001);  // Early set, before self-clear
        repeat (8) @(negedge sys_clk_in);
        reg_read(2'h0, rd);
        check_reg(32'h0, rd);
        reg_write(2'h3, 32'hFFFF_FFFF);
        reg_read(2'h1, rd);
        check_reg(32'h0, rd);
        reg_read(2'h3, rd);
        check_reg(32'h0, rd);
        reg_read(2'h2, rd);
        check_reg(vsfrc_pkg::FRAME_CTRL_RST, rd);
        stall_en = 1'b1;
        send_pkt(4'hF, 5);
        wait_drain();
        check_reg(32'h0, 32'(exp_q.size()));
        send_pkt(4'h0, 9);
        repeat (40) @(negedge sys_clk_in);
        check_reg(32'hA, 32'(exp_q.size()));
        reg_read(2'h1, rd);
        check_reg(32'h0, rd);
        fc = $random(seed);
        reg_write(2'h2, fc);
        reg_write(2'h0, 32'hFFFF_FFFF);
        reg_read(2'h0, rd);
        check_reg(32'h1, rd);
        wait_drain();
        check_reg(fc, frame_ctrl_out);
        reg_read(2'h1, rd);
        check_reg(32'h1, rd);
        send_pkt(4'h0, 30);
        repeat (6) @(negedge sys_clk_in);
        reg_write(2'h0, 32'h0);  // Clear mid-frame
        send_pkt(4'h3, 2);
        send_pkt(4'h0, 4);
        repeat (150) @(negedge sys_clk_in);
        check_reg(32'h5, 32'(exp_q.size()));
        reg_read(2'h1, rd);
        check_reg(32'h0, rd);
        reg_write(2'h2, ~fc);
        check_reg(fc, frame_ctrl_out);
        reg_write(2'h0, 32'h1);
        send_pkt(4'h0, 0);  // Empty video frame
        wait_drain();
        check_reg(~fc, frame_ctrl_out);
        check_reg(32'h0, 32'(exp_q.size()));
        stop_test();
    end
endmodule : tb_vsfrc_top

bind vsfrc_top vsfrc_monitor #(.BUF_DEPTH(BUF_DEPTH)) i_vsfrc_monitor (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .din_valid_in(din_valid_in),
    .din_beat_in(din_beat_in), .din_ready_out(din_ready_out), .dout_beat_out(dout_beat_out),
    .dout_valid_out(dout_valid_out), .dout_ready_in(dout_ready_in),
    .ctrl_address_in(ctrl_address_in), .ctrl_read_in(ctrl_read_in),
    .ctrl_write_in(ctrl_write_in), .ctrl_writedata_in(ctrl_writedata_in),
    .ctrl_readdata_out(ctrl_readdata_out), .frame_ctrl_out(frame_ctrl_out));

`default_nettype wire

// >>> dv/vsfrc_monitor.sv
/*
 * Checker for the frame run control stage, watching only the top ports.
 * Assumes it is bound onto vsfrc_top and shares its main clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none

module vsfrc_monitor #(
    parameter int unsigned BUF_DEPTH = 4
) (
    input wire logic                   sys_clk_in,
    input wire logic                   reset_in,
    input wire logic                   din_valid_in,
    input var  vsfrc_pkg::vsfrc_beat_t din_beat_in,
    input wire logic                   din_ready_out,
    input var  vsfrc_pkg::vsfrc_beat_t dout_beat_out,
    input wire logic                   dout_valid_out,
    input wire logic                   dout_ready_in,
    input wire logic [1:0]             ctrl_address_in,
    input wire logic                   ctrl_read_in,
    input wire logic                   ctrl_write_in,
    input wire logic [31:0]            ctrl_writedata_in,
    input wire logic [31:0]            ctrl_readdata_out,
    input wire logic [31:0]            frame_ctrl_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    logic       in_pkt_ff;   // Inside an output packet
    logic       go_ff;       // Shadow of the run-enable flag
    logic       go_seen_ff;  // Run-enable seen since last packet end
    logic       rdy_p_ff;    // Input ready of the previous cycle
    logic [2:0] rel_cnt_ff;  // Cycles since reset release, saturating
    int         fill_ff;     // Beats taken in but not yet shown out
    wire        vid_hdr = dout_valid_out && dout_beat_out.sop
                          && dout_beat_out.data[3:0] == vsfrc_pkg::TYPE_VIDEO;

    // Shadow state; self-clear mirrors the 5th edge after release
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            {in_pkt_ff, go_ff, go_seen_ff, rdy_p_ff, rel_cnt_ff, fill_ff} <= '0;
        end else begin
            rdy_p_ff   <= din_ready_out;
            rel_cnt_ff <= (rel_cnt_ff == 3'h5) ? 3'h5 : rel_cnt_ff + 3'h1;
            if (dout_valid_out) in_pkt_ff <= !dout_beat_out.eop;
            if (ctrl_write_in && ctrl_address_in == 2'h0) go_ff <= ctrl_writedata_in[0];
            else if (rel_cnt_ff == 3'h4) go_ff <= 1'b0;
            go_seen_ff <= go_ff || (go_seen_ff && !(dout_valid_out && dout_beat_out.eop));
            fill_ff    <= fill_ff + int'(din_valid_in && rdy_p_ff) - int'(dout_valid_out);
        end
    end

    // Register read of a one-bit or unmapped place
    sequence narrow_read_s;
        $rose(ctrl_read_in) && ctrl_address_in != vsfrc_pkg::REG_FRAME_CTRL;
    endsequence

    valid_needs_ready_a: assert property (dout_valid_out |-> $past(dout_ready_in))
        else $error("output valid without ready one cycle before");
    beat_holds_a: assert property (!dout_valid_out |-> $stable(dout_beat_out))
        else $error("output beat changed while not valid");
    sop_first_a: assert property (dout_valid_out |-> dout_beat_out.sop == !in_pkt_ff)
        else $error("start flag not on first beat only");
    fill_bound_a: assert property (fill_ff <= int'(BUF_DEPTH) + 2)
        else $error("input taken beyond buffer room");
    unused_bits_a: assert property (narrow_read_s |-> ##2 ctrl_readdata_out[31:1] == 31'h0)
        else $error("unused read bits not zero");
    read_stable_a: assert property ((!ctrl_read_in) [*3] |-> $stable(ctrl_readdata_out))
        else $error("read data moved without a read");
    go_gate_a: assert property (vid_hdr |-> go_seen_ff)
        else $error("video header sent without run enable");
    ctrl_swap_a: assert property ($changed(frame_ctrl_out) |-> !in_pkt_ff)
        else $error("frame control changed inside a packet");
endmodule : vsfrc_monitor

`default_nettype wire

// >>> dv/vsfrc_sink_model.sv
/*
 * Downstream sink model: drives ready with a stall pattern when asked.
 * Assumes the bench takes every valid beat, including the late one.
 */
`timescale 1ns/1ps
`default_nettype none

module vsfrc_sink_model (
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    input  wire logic stall_en_in,
    output logic      dout_ready_out
);
    logic [2:0] phase_ff;  // Position in a five-cycle stall pattern

    // ready drops two cycles in five, late beat still taken
    always @(negedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            phase_ff       <= 3'h0;
            dout_ready_out <= 1'b1;
        end else begin
            phase_ff       <= (phase_ff == 3'h4) ? 3'h0 : phase_ff + 3'h1;
            dout_ready_out <= !stall_en_in || phase_ff < 3'h3;
        end
    end
endmodule : vsfrc_sink_model

`default_nettype wire

// >>> rtl/vsfrc_in_buf.sv
/*
 * Small show-ahead input buffer with a ready-latency-of-one sink port.
 * Assumes the upstream source only sends in the cycle after ready was high,
 * and that the reader pops only while rd_valid_out is high.
 */
`timescale 1ns/1ps
`default_nettype none

module vsfrc_in_buf #(
    parameter int unsigned DEPTH = vsfrc_pkg::IN_BUF_DEPTH
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  din_valid_in,
    input  var  vsfrc_pkg::vsfrc_beat_t din_beat_in,
    output logic                       din_ready_out,
    output vsfrc_pkg::vsfrc_beat_t     rd_beat_out,
    output logic                       rd_valid_out,
    input  wire logic                  rd_pop_in
);
    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);

    vsfrc_pkg::vsfrc_beat_t mem [DEPTH];   // Beat storage
    logic [PTR_W-1:0] wr_ptr_ff;           // Next slot to fill
    logic [PTR_W-1:0] rd_ptr_ff;           // Oldest slot
    logic [CNT_W-1:0] count_ff;            // Beats held
    logic             ready_q_ff;          // Ready as seen one cycle late
    logic             accept;              // Beat taken this cycle
    logic             pop;                 // Beat leaves this cycle
    logic [CNT_W-1:0] nxt_count;

    // Ready granted last cycle makes this cycle's valid a transfer
    assign accept = din_valid_in & ready_q_ff;
    assign pop    = rd_pop_in & rd_valid_out;
    assign nxt_count = count_ff + CNT_W'(accept) - CNT_W'(pop);

    // Keep room for the beat that may still land after ready drops
    assign din_ready_out = (32'(count_ff) + 32'(accept)) < DEPTH;
    assign rd_valid_out  = count_ff != '0;
    assign rd_beat_out   = mem[rd_ptr_ff];

    // Pointers, occupancy and latched ready
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_ptr_ff  <= '0;
            rd_ptr_ff  <= '0;
            count_ff   <= '0;
            ready_q_ff <= 1'b0;
        end else begin
            wr_ptr_ff  <= accept ? PTR_W'((32'(wr_ptr_ff) + 1) % DEPTH) : wr_ptr_ff;
            rd_ptr_ff  <= pop ? PTR_W'((32'(rd_ptr_ff) + 1) % DEPTH) : rd_ptr_ff;
            count_ff   <= nxt_count;
            ready_q_ff <= din_ready_out;
        end
    end

    // Storage has no reset; slots are only read once written
    always_ff @(posedge sys_clk_in) begin
        if (accept) begin
            mem[wr_ptr_ff] <= din_beat_in;
        end
    end

endmodule : vsfrc_in_buf

`default_nettype wire

// >>> rtl/vsfrc_pkg.sv
/*
 * Shared constants and types for the video stream frame run control stage:
 * control register indexes, field positions, reset values, timing counts,
 * the stream beat carrier and the frame sequencing states.
 * Assumes a single clock domain; nothing here holds state.
 */
package vsfrc_pkg;

    // Stream geometry: one 8-bit sample a beat, planes sent in sequence
    localparam int unsigned BITS_PER_SAMPLE = 8;
    localparam int unsigned PLANES_PAR      = 1;
    localparam int unsigned DATA_W          = BITS_PER_SAMPLE * PLANES_PAR;

    // Packet type sits in the low four bits of the first plane
    localparam int unsigned TYPE_LSB        = 0;
    localparam int unsigned TYPE_W          = 4;
    localparam logic [3:0]  TYPE_VIDEO      = 4'h0;

    // Control slave geometry
    localparam int unsigned CTRL_ADDR_W     = 2;
    localparam int unsigned CTRL_DATA_W     = 32;

    // Register indexes on the control slave
    localparam logic [1:0]  REG_RUN_ENABLE  = 2'h0;
    localparam logic [1:0]  REG_RUN_STATUS  = 2'h1;
    localparam logic [1:0]  REG_FRAME_CTRL  = 2'h2;

    // Field positions
    localparam int unsigned RUN_ENABLE_BIT  = 0;
    localparam int unsigned RUN_STATUS_BIT  = 0;

    // Reset values
    localparam logic        RUN_ENABLE_RST  = 1'b0;
    localparam logic        RUN_STATUS_RST  = 1'b0;
    localparam logic [31:0] FRAME_CTRL_RST  = 32'h0000_0000;

    // Cycles after reset release before the run-enable flag is self-cleared
    localparam logic [2:0]  GO_CLEAR_CYCLES = 3'h4;

    // Input buffer depth in beats
    localparam int unsigned IN_BUF_DEPTH    = 4;

    // One stream beat as it travels through the stage
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              sop;
        logic              eop;
    } vsfrc_beat_t;

    // Frame sequencing states
    typedef enum logic [2:0] {
        ST_PKT_FIRST = 3'b000,
        ST_PKT_BODY  = 3'b001,
        ST_WAIT_GO   = 3'b010,
        ST_SEND_HDR  = 3'b011,
        ST_FRAME     = 3'b100
    } vsfrc_state_t;

endpackage : vsfrc_pkg

// >>> rtl/vsfrc_top.sv
/*
 * Video stream frame run control stage: passes a packetised video stream
 * from sink to source, halts at each image packet until run-enable is set,
 * reports running status and double-buffers one frame control word.
 * Assumes upstream and downstream use ready latency one on the main clock,
 * and that the controller holds a read for three cycles (two wait states).
 */
`timescale 1ns/1ps
`default_nettype none

module vsfrc_top #(
    parameter int unsigned BUF_DEPTH = vsfrc_pkg::IN_BUF_DEPTH
) (
    input  wire logic                                  sys_clk_in,
    input  wire logic                                  reset_in,
    // Stream sink
    input  wire logic                                  din_valid_in,
    input  var  vsfrc_pkg::vsfrc_beat_t                din_beat_in,
    output logic                                       din_ready_out,
    // Stream source
    output vsfrc_pkg::vsfrc_beat_t                     dout_beat_out,
    output logic                                       dout_valid_out,
    input  wire logic                                  dout_ready_in,
    // Control slave
    input  wire logic [vsfrc_pkg::CTRL_ADDR_W-1:0]     ctrl_address_in,
    input  wire logic                                  ctrl_read_in,
    input  wire logic                                  ctrl_write_in,
    input  wire logic [vsfrc_pkg::CTRL_DATA_W-1:0]     ctrl_writedata_in,
    output logic [vsfrc_pkg::CTRL_DATA_W-1:0]          ctrl_readdata_out,
    // Frame control word latched at frame start, for the processing core
    output logic [vsfrc_pkg::CTRL_DATA_W-1:0]          frame_ctrl_out
);
    localparam int unsigned AW = vsfrc_pkg::CTRL_ADDR_W;
    localparam int unsigned CW = vsfrc_pkg::CTRL_DATA_W;

    // Buffered input side
    vsfrc_pkg::vsfrc_beat_t buf_beat;      // Oldest buffered beat
    logic                   buf_valid;     // A beat is waiting
    logic                   buf_pop;       // Beat leaves the buffer

    // Sequencing
    vsfrc_pkg::vsfrc_state_t state_ff;     // Frame sequencer state
    vsfrc_pkg::vsfrc_state_t nxt_state;
    vsfrc_pkg::vsfrc_beat_t  hdr_ff;       // Held video type beat
    logic                    is_video_hdr; // Buffered beat opens a video packet
    logic                    fire;         // Output beat launched this edge
    logic                    fire_first;   // Forward first beat of a non-video packet
    logic                    fire_body;    // Forward a body beat
    logic                    fire_hdr;     // Emit held video type beat
    logic                    take_hdr;     // Swallow video type beat
    logic                    start_frame;  // Run-enable seen while halted
    vsfrc_pkg::vsfrc_beat_t  out_sel;      // Beat chosen for the output register

    // Output register
    vsfrc_pkg::vsfrc_beat_t dout_beat_ff;
    logic                   dout_valid_ff;

    // Control registers
    logic          run_enable_ff;          // Software run request
    logic          run_status_ff;          // Stage is processing a frame
    logic [CW-1:0] frame_ctrl_ff;          // Software side, written any time
    logic [CW-1:0] frame_ctrl_act_ff;      // Copy in use for the current frame
    logic [2:0]    go_clr_cnt_ff;          // Cycles since reset release
    logic          go_clr_done_ff;         // Self-clear already done
    logic          go_clr_now;             // Self-clear happens this edge
    logic          wr_run_enable;          // Write hits register 0
    logic          wr_frame_ctrl;          // Write hits frame control word

    // Read pipeline: two registered stages give two wait states
    logic          rd_stage_ff;
    logic [AW-1:0] rd_addr_ff;
    logic [CW-1:0] rd_mux;
    logic [CW-1:0] readdata_ff;

    // input buffer keeps space for the late beat
    // beat after ready drop is stored
    vsfrc_in_buf #(
        .DEPTH          (BUF_DEPTH)
    ) u_in_buf (
        .sys_clk_in     (sys_clk_in),
        .reset_in       (reset_in),
        .din_valid_in   (din_valid_in),
        .din_beat_in    (din_beat_in),
        .din_ready_out  (din_ready_out),
        .rd_beat_out    (buf_beat),
        .rd_valid_out   (buf_valid),
        .rd_pop_in      (buf_pop)
    );

    // type lives in the first beat's low nibble
    // control words use only the low four bits per plane
    assign is_video_hdr = buf_beat.sop &&
        (buf_beat.data[vsfrc_pkg::TYPE_LSB +: vsfrc_pkg::TYPE_W] == vsfrc_pkg::TYPE_VIDEO);

    // a launch needs ready now, so valid shows one cycle later
    // no launch while the sink is not ready
    assign fire_first = (state_ff == vsfrc_pkg::ST_PKT_FIRST) && buf_valid &&
                        !is_video_hdr && dout_ready_in;
    assign fire_body  = ((state_ff == vsfrc_pkg::ST_PKT_BODY) ||
                         (state_ff == vsfrc_pkg::ST_FRAME)) && buf_valid && dout_ready_in;
    assign fire_hdr   = (state_ff == vsfrc_pkg::ST_SEND_HDR) && dout_ready_in;
    assign fire       = fire_first | fire_body | fire_hdr;

    // video type beat leaves the input before run-enable is tested
    assign take_hdr    = (state_ff == vsfrc_pkg::ST_PKT_FIRST) && buf_valid && is_video_hdr;
    assign start_frame = (state_ff == vsfrc_pkg::ST_WAIT_GO) && run_enable_ff;

    // pixels behind the header stay buffered while halted
    assign buf_pop = fire_first | fire_body | take_hdr;

    // start flag only on a packet's first beat
    assign out_sel.data = fire_hdr ? hdr_ff.data : buf_beat.data;
    assign out_sel.sop  = fire_hdr | (fire_first & buf_beat.sop);
    assign out_sel.eop  = fire_hdr ? hdr_ff.eop : buf_beat.eop;

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            vsfrc_pkg::ST_PKT_FIRST: begin
                // non-image packets pass, video header stops
                if (take_hdr) begin
                    nxt_state = vsfrc_pkg::ST_WAIT_GO;
                end else if (fire_first && !buf_beat.eop) begin
                    nxt_state = vsfrc_pkg::ST_PKT_BODY;
                end
            end
            vsfrc_pkg::ST_PKT_BODY: begin
                // Pass body beats to the end
                if (fire_body && buf_beat.eop) begin
                    nxt_state = vsfrc_pkg::ST_PKT_FIRST;
                end
            end
            vsfrc_pkg::ST_WAIT_GO: begin
                if (start_frame) begin
                    nxt_state = vsfrc_pkg::ST_SEND_HDR;
                end
            end
            vsfrc_pkg::ST_SEND_HDR: begin
                // A header carrying end of packet is an empty frame
                if (fire_hdr) begin
                    nxt_state = hdr_ff.eop ? vsfrc_pkg::ST_PKT_FIRST : vsfrc_pkg::ST_FRAME;
                end
            end
            vsfrc_pkg::ST_FRAME: begin
                // run-enable is not looked at until the frame ends
                if (fire_body && buf_beat.eop) begin
                    nxt_state = vsfrc_pkg::ST_PKT_FIRST;
                end
            end
            default: begin
                // Stray codes restart
                nxt_state = vsfrc_pkg::ST_PKT_FIRST;
            end
        endcase
    end

    // sequencer and held header on the main clock and reset
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            // Look for a first beat
            state_ff <= vsfrc_pkg::ST_PKT_FIRST;
            hdr_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            // Kept for sending after release
            hdr_ff   <= take_hdr ? buf_beat : hdr_ff;
        end
    end

    // valid falls when nothing launched; data holds meanwhile
    // first launch after ready returns restores valid
    // one sample per beat, order kept as received
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            // Nothing offered out of reset
            dout_valid_ff <= 1'b0;
            dout_beat_ff  <= '0;
        end else begin
            // One cycle of valid per launch
            dout_valid_ff <= fire;
            dout_beat_ff  <= fire ? out_sel : dout_beat_ff;
        end
    end

    assign dout_valid_out = dout_valid_ff;
    assign dout_beat_out  = dout_beat_ff;

    // Write decode: zero wait states, applied at the write edge
    assign wr_run_enable = ctrl_write_in && (ctrl_address_in == vsfrc_pkg::REG_RUN_ENABLE);
    assign wr_frame_ctrl = ctrl_write_in && (ctrl_address_in == vsfrc_pkg::REG_FRAME_CTRL);
    assign go_clr_now    = !go_clr_done_ff && (go_clr_cnt_ff == vsfrc_pkg::GO_CLEAR_CYCLES);

    // Post-reset counter for the one-time run-enable clear
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            go_clr_cnt_ff  <= '0;
            go_clr_done_ff <= 1'b0;
        end else begin
            // Counter freezes after the clear
            go_clr_cnt_ff  <= go_clr_done_ff ? go_clr_cnt_ff : go_clr_cnt_ff + 3'h1;
            go_clr_done_ff <= go_clr_done_ff | go_clr_now;
        end
    end

    // run-enable bit, self-cleared once; a same-cycle write wins
    // writes land with no wait state
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            run_enable_ff <= vsfrc_pkg::RUN_ENABLE_RST;
        end else if (wr_run_enable) begin
            // Only bit 0 is kept
            run_enable_ff <= ctrl_writedata_in[vsfrc_pkg::RUN_ENABLE_BIT];
        end else if (go_clr_now) begin
            // One-time clear after reset
            run_enable_ff <= 1'b0;
        end
    end

    // running while a frame is released
    // cleared once the video header is taken
    // set when the frame is released
    // no write path reaches this bit
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            run_status_ff <= vsfrc_pkg::RUN_STATUS_RST;
        end else if (start_frame) begin
            // Frame released
            run_status_ff <= 1'b1;
        end else if (take_hdr) begin
            // Halting at a video header
            run_status_ff <= 1'b0;
        end
    end

    // software copy may change at any time
    // active copy loads only at frame release
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            frame_ctrl_ff     <= vsfrc_pkg::FRAME_CTRL_RST;
            frame_ctrl_act_ff <= vsfrc_pkg::FRAME_CTRL_RST;
        end else begin
            // A write at release lands next frame
            frame_ctrl_ff     <= wr_frame_ctrl ? ctrl_writedata_in : frame_ctrl_ff;
            frame_ctrl_act_ff <= start_frame ? frame_ctrl_ff : frame_ctrl_act_ff;
        end
    end

    assign frame_ctrl_out = frame_ctrl_act_ff;

    // unused bits and unmapped indexes read zero
    assign rd_mux =
        (rd_addr_ff == vsfrc_pkg::REG_RUN_ENABLE) ? CW'(run_enable_ff) :
        (rd_addr_ff == vsfrc_pkg::REG_RUN_STATUS) ? CW'(run_status_ff) :
        (rd_addr_ff == vsfrc_pkg::REG_FRAME_CTRL) ? frame_ctrl_ff      : '0;

    // address caught at the first edge, data out after the second
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_stage_ff <= 1'b0;
            rd_addr_ff  <= '0;
            readdata_ff <= '0;
        end else begin
            // Marks a read in flight
            rd_stage_ff <= ctrl_read_in;
            rd_addr_ff  <= ctrl_read_in ? ctrl_address_in : rd_addr_ff;
            // Held for a slow master
            readdata_ff <= rd_stage_ff ? rd_mux : readdata_ff;
        end
    end

    assign ctrl_readdata_out = readdata_ff;

endmodule : vsfrc_top

`default_nettype wire
